//--- include/clms_pkg.sv
// constants and types for closed loop mode selection
// assumes one clock domain shared by controller end and drive end
// Behaviour
// R1: system select 0 semi, 1 fully closed
// R2: function 0: fully closed always, ignore switching
// R3: function 1: command or input selects fully
// R4: unassigned loop select input reads off
// R5: function select only matters in fully system; the parameter alarm (R6) still follows it in semi system too
// R6: function 1 with absolute detect: parameter alarm
// R7: absolute detect availability depends on method
// R8: droop clear switching needs repeated homing
// R9: wire method 0 two-wire, 1 four-wire
// R10: differential phase encoder needs wire method 0
// R11: wire method mismatch raises alarms a, b
// R12: two-axis unit uses two-wire method only
// R13: two-axis with phase rotary raises alarm a
// R14: alarms latch until corrected and cleared
`default_nettype none
package clms_pkg;
	localparam logic SYS_SEMI = 1'b0;
	localparam logic SYS_FULL = 1'b1;
	localparam logic LFS_FIXED = 1'b0;
	localparam logic LFS_SWITCHED = 1'b1;
	localparam logic DROOP_ENABLED = 1'b0;
	localparam logic WIRE_TWO = 1'b0;
	localparam logic WIRE_FOUR = 1'b1;
	// register byte offsets of the controller end
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	// control register fields
	localparam int CTRL_SYS = 0;
	localparam int CTRL_LFS = 1;
	localparam int CTRL_ABS = 2;
	localparam int CTRL_DROOP = 3;
	localparam int CTRL_WIRE = 4;
	localparam int CTRL_CMD = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h08;
	// status register fields
	localparam int ST_FULL = 0;
	localparam int ST_UNIT = 1;
	localparam int ST_ABS = 2;
	localparam int ST_PAR = 3;
	localparam int ST_ENC_A = 4;
	localparam int ST_ENC_B = 5;
	localparam int ST_HOME = 6;
	localparam int ST_W = 7;
	// interrupt status and mask fields
	localparam int IRQ_PAR = 0;
	localparam int IRQ_ENC_A = 1;
	localparam int IRQ_ENC_B = 2;
	localparam int IRQ_SWITCH = 3;
	localparam int IRQ_HOME = 4;
	localparam int IRQ_W = 5;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
	// command register fields
	localparam int CMD_ALARM_CLR = 0;
	localparam int CMD_HOME_DONE = 1;
	typedef enum logic {METH_SEMI, METH_FULL} clms_method_t;
endpackage : clms_pkg
`default_nettype wire

//--- include/clms_if.sv
// link between motion controller end and drive end
// assumes both ends run on sys_clk; all signals are levels except pulses noted
`default_nettype none
interface clms_if;
	// controller to drive: settings and command
	logic closed_loop_system_select;
	logic loop_function_select;
	logic absolute_detect_enable;
	logic droop_clear_on_switch;
	logic encoder_wire_method_select;
	logic loop_select_command;
	logic alarm_clear;                // one-cycle pulse
	// drive to controller: state and alarms
	logic fully_closed_active;
	logic command_unit_load;
	logic abs_detect_active;
	logic parameter_error_alarm;
	logic encoder_config_alarm_a;
	logic encoder_config_alarm_b;
	logic method_switched;            // one-cycle pulse
	modport device (
		input  closed_loop_system_select,
		input  loop_function_select,
		input  absolute_detect_enable,
		input  droop_clear_on_switch,
		input  encoder_wire_method_select,
		input  loop_select_command,
		input  alarm_clear,
		output fully_closed_active,
		output command_unit_load,
		output abs_detect_active,
		output parameter_error_alarm,
		output encoder_config_alarm_a,
		output encoder_config_alarm_b,
		output method_switched
	);
	modport host (
		output closed_loop_system_select,
		output loop_function_select,
		output absolute_detect_enable,
		output droop_clear_on_switch,
		output encoder_wire_method_select,
		output loop_select_command,
		output alarm_clear,
		input  fully_closed_active,
		input  command_unit_load,
		input  abs_detect_active,
		input  parameter_error_alarm,
		input  encoder_config_alarm_a,
		input  encoder_config_alarm_b,
		input  method_switched
	);
endinterface : clms_if
`default_nettype wire

//--- design/clms_device.sv
// drive end: picks semi or fully closed loop control and checks setup
// assumes settings on the link are held by the controller end, and that
// encoder detection and pin assignment inputs are synchronous to sys_clk
`default_nettype none
module clms_device (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// controller link
	clms_if.device                    link,
	// loop select input pin and its assignment
	input  wire logic                 loop_select_input,
	input  wire logic                 loop_select_assigned,
	// load encoder port detection
	input  wire logic                 encoder_present,
	input  wire logic                 encoder_four_wire,
	input  wire logic                 encoder_abz,
	input  wire logic                 encoder_abz_rotary,
	input  wire logic                 encoder_absolute,
	input  wire logic                 two_axis_unit,
	// control outputs
	output var  clms_pkg::clms_method_t control_method,
	output logic                      port_four_wire,
	output logic                      droop_clear_strobe,
	output logic                      alarm_any
);
	import clms_pkg::*;

	// registered copies of the controller settings, and the gated loop select input
	logic          cfg_system;
	logic          cfg_lfs;
	logic          cfg_abs;
	logic          cfg_droop;
	logic          cfg_wire;
	logic          cfg_command;
	logic          cfg_clear;
	logic          loop_sel_eff;
	// method selection
	clms_method_t  next_method;
	logic          abs_available;
	// alarm conditions
	logic          par_cond;
	logic          mismatch_cond;
	logic          phase_rotary_cond;
	logic          alarm_par;
	logic          alarm_a;
	logic          alarm_b;

	// latched alarm: a standing cause wins over a clear in the same cycle
	function automatic logic sticky (
		input logic cause,
		input logic held,
		input logic clear
	);
		sticky = cause | (held & ~clear);
	endfunction : sticky

	// capture settings once per cycle so all decisions use one snapshot
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_system  <= SYS_SEMI;
			cfg_lfs     <= LFS_FIXED;
			cfg_abs     <= 1'b0;
			cfg_droop   <= DROOP_ENABLED;
			cfg_wire    <= WIRE_TWO;
			cfg_command <= 1'b0;
			cfg_clear   <= 1'b0;
		end
		else
		begin
			cfg_system  <= link.closed_loop_system_select;
			cfg_lfs     <= link.loop_function_select;
			cfg_abs     <= link.absolute_detect_enable;
			cfg_droop   <= link.droop_clear_on_switch;
			cfg_wire    <= link.encoder_wire_method_select;
			cfg_command <= link.loop_select_command;
			cfg_clear   <= link.alarm_clear;
		end
	end

	// input pin counts only when mapped to a device pin
	assign loop_sel_eff = loop_select_input & loop_select_assigned; // [R4]

	// method decision: system first, then function, then switch signals
	always_comb
	begin
		if (cfg_system == SYS_SEMI)
		begin
			next_method = METH_SEMI; // [R1] [R5]
		end
		else if (cfg_lfs == LFS_FIXED)
		begin
			next_method = METH_FULL; // [R2]
		end
		else if (cfg_command | loop_sel_eff)
		begin
			next_method = METH_FULL; // [R3]
		end
		else
		begin
			next_method = METH_SEMI; // [R3]
		end
	end

	// absolute detection: semi system always, fixed fully only with
	// an absolute load encoder, never while switching is allowed
	always_comb
	begin
		if (cfg_system == SYS_SEMI)
		begin
			abs_available = 1'b1; // [R7]
		end
		else if (cfg_lfs == LFS_FIXED)
		begin
			abs_available = encoder_absolute; // [R7]
		end
		else
		begin
			abs_available = 1'b0; // [R7]
		end
	end

	// alarm causes, evaluated continuously from the settings snapshot
	assign par_cond = (cfg_lfs == LFS_SWITCHED) & cfg_abs; // [R6]
	// wire method must match the encoder; phase interface needs two-wire
	assign mismatch_cond = encoder_present
		& (((cfg_wire == WIRE_FOUR) != encoder_four_wire)
		| (encoder_abz & (cfg_wire != WIRE_TWO))); // [R11]
	// phase rotary encoders are not usable on a two-axis unit
	assign phase_rotary_cond = encoder_present & two_axis_unit
		& encoder_abz_rotary; // [R13]

	// active control method and its switch events
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			control_method     <= METH_SEMI;
			link.method_switched <= 1'b0;
			droop_clear_strobe <= 1'b0;
		end
		else
		begin
			control_method       <= next_method;
			link.method_switched <= (next_method != control_method);
			// droop pulses are cleared on a switch only when enabled
			droop_clear_strobe   <= (next_method != control_method)
				& (cfg_droop == DROOP_ENABLED);
		end
	end

	// reported state: method, command unit, absolute detection
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.fully_closed_active <= 1'b0;
			link.command_unit_load   <= 1'b0;
			link.abs_detect_active   <= 1'b0;
		end
		else
		begin
			link.fully_closed_active <= (next_method == METH_FULL);
			link.command_unit_load   <= (cfg_system == SYS_FULL); // [R1]
			link.abs_detect_active   <= cfg_abs & abs_available; // [R7]
		end
	end

	// encoder port wiring follows the wire method setting
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			port_four_wire <= 1'b0;
		end
		else
		begin
			port_four_wire <= (cfg_wire == WIRE_FOUR); // [R9]
		end
	end

	// alarm latches: held until the cause is gone and a clear arrives
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			alarm_par <= 1'b0;
			alarm_a   <= 1'b0;
			alarm_b   <= 1'b0;
		end
		else
		begin
			alarm_par <= sticky(par_cond, alarm_par, cfg_clear); // [R6] [R14]
			alarm_a   <= sticky(mismatch_cond | phase_rotary_cond,
				alarm_a, cfg_clear); // [R11] [R13] [R14]
			alarm_b   <= sticky(mismatch_cond, alarm_b, cfg_clear); // [R11] [R14]
		end
	end

	// alarm reporting to the controller and the summary pin
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.parameter_error_alarm  <= 1'b0;
			link.encoder_config_alarm_a <= 1'b0;
			link.encoder_config_alarm_b <= 1'b0;
			alarm_any                   <= 1'b0;
		end
		else
		begin
			link.parameter_error_alarm  <= alarm_par; // [R14]
			link.encoder_config_alarm_a <= alarm_a;
			link.encoder_config_alarm_b <= alarm_b;
			alarm_any                   <= alarm_par | alarm_a | alarm_b;
		end
	end
endmodule : clms_device
`default_nettype wire

//--- design/clms_controller.sv
// controller end: register port for software, drives settings to the drive
// assumes a single-cycle strobe bus master on sys_clk
`default_nettype none
module clms_controller (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// drive link
	clms_if.host             link,
	// software register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// machine setup and interrupt
	input  wire logic        abz_encoder_used,
	input  wire logic        two_axis_unit,
	output logic             irq
);
	import clms_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  events;
	logic [2:0]        alarm_prev;
	logic              homing_required;
	logic              wr_ctrl;
	logic              wr_stat;
	logic              wr_mask;
	logic              wr_cmd;
	logic              home_cause;
	logic [ST_W-1:0]   status;

	// address decode
	assign wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
	assign wr_stat = reg_wr & (reg_addr == OFS_IRQ_STAT);
	assign wr_mask = reg_wr & (reg_addr == OFS_IRQ_MASK);
	assign wr_cmd  = reg_wr & (reg_addr == OFS_CMD);

	// settings register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= reg_wdata[CTRL_W-1:0];
	end

	// settings to the drive; wire method forced to two-wire when required
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.closed_loop_system_select  <= SYS_SEMI;
			link.loop_function_select       <= LFS_FIXED;
			link.absolute_detect_enable     <= 1'b0;
			link.droop_clear_on_switch      <= CTRL_RESET[CTRL_DROOP];
			link.encoder_wire_method_select <= WIRE_TWO;
			link.loop_select_command        <= 1'b0;
			link.alarm_clear                <= 1'b0;
		end
		else
		begin
			link.closed_loop_system_select  <= ctrl[CTRL_SYS];
			link.loop_function_select       <= ctrl[CTRL_LFS];
			link.absolute_detect_enable     <= ctrl[CTRL_ABS];
			link.droop_clear_on_switch      <= ctrl[CTRL_DROOP];
			link.encoder_wire_method_select <= ctrl[CTRL_WIRE]
				& ~abz_encoder_used & ~two_axis_unit; // [R10] [R12]
			link.loop_select_command        <= ctrl[CTRL_CMD]; // [R3]
			link.alarm_clear                <= wr_cmd & reg_wdata[CMD_ALARM_CLR];
		end
	end

	// a switch with droop clearing enabled calls for homing again
	assign home_cause = link.method_switched
		& (ctrl[CTRL_DROOP] == DROOP_ENABLED); // [R8]

	// homing flag: set wins over the clear from software
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			homing_required <= 1'b0;
		else
			homing_required <= home_cause
				| (homing_required & ~(wr_cmd & reg_wdata[CMD_HOME_DONE])); // [R8]
	end

	// rising edges of alarms and the switch events
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			alarm_prev <= 3'h0;
		else
			alarm_prev <= {link.encoder_config_alarm_b,
				link.encoder_config_alarm_a, link.parameter_error_alarm};
	end
	assign events[IRQ_PAR]    = link.parameter_error_alarm & ~alarm_prev[0];
	assign events[IRQ_ENC_A]  = link.encoder_config_alarm_a & ~alarm_prev[1];
	assign events[IRQ_ENC_B]  = link.encoder_config_alarm_b & ~alarm_prev[2];
	assign events[IRQ_SWITCH] = link.method_switched;
	assign events[IRQ_HOME]   = home_cause;

	// sticky interrupt status, write one to clear, new event wins
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_stat <= '0;
		else if (wr_stat)
			irq_stat <= events | (irq_stat & ~reg_wdata[IRQ_W-1:0]);
		else
			irq_stat <= events | irq_stat;
	end

	// interrupt mask
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_mask <= IRQ_MASK_RESET;
		else if (wr_mask)
			irq_mask <= reg_wdata[IRQ_W-1:0];
	end

	// interrupt output
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end

	// status word assembled from drive state
	assign status[ST_FULL]  = link.fully_closed_active;
	assign status[ST_UNIT]  = link.command_unit_load;
	assign status[ST_ABS]   = link.abs_detect_active;
	assign status[ST_PAR]   = link.parameter_error_alarm; // [R14]
	assign status[ST_ENC_A] = link.encoder_config_alarm_a;
	assign status[ST_ENC_B] = link.encoder_config_alarm_b;
	assign status[ST_HOME]  = homing_required;

	// read data in the cycle after the read strobe only
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 32'h0000_0000;
		else if (!reg_rd)
			reg_rdata <= 32'h0000_0000;
		else
		begin
			unique case (reg_addr)
				OFS_CTRL:     reg_rdata <= {{(32-CTRL_W){1'b0}}, ctrl};
				OFS_STATUS:   reg_rdata <= {{(32-ST_W){1'b0}}, status};
				OFS_IRQ_STAT: reg_rdata <= {{(32-IRQ_W){1'b0}}, irq_stat};
				OFS_IRQ_MASK: reg_rdata <= {{(32-IRQ_W){1'b0}}, irq_mask};
				default:      reg_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : clms_controller
`default_nettype wire

//--- bench/clms_properties.sv
// link checker: drive end answers to the settings carried on the link
// assumes each link signal is wired by name; outputs lag settings two edges, alarms three
`default_nettype none
module clms_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// controller to drive
	input wire logic closed_loop_system_select,
	input wire logic loop_function_select,
	input wire logic absolute_detect_enable,
	input wire logic loop_select_command,
	input wire logic alarm_clear,
	// drive to controller
	input wire logic fully_closed_active,
	input wire logic command_unit_load,
	input wire logic abs_detect_active,
	input wire logic parameter_error_alarm,
	input wire logic encoder_config_alarm_a,
	input wire logic method_switched
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	logic [2:0] clr_seen;
	// alarm clear pulses of the last three edges, so a falling alarm can be traced
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			clr_seen <= 3'h0;
		else
			clr_seen <= {clr_seen[1:0], alarm_clear};
	end
	// control method and units follow the settings
	unit_follows_a: assert property (command_unit_load == $past(closed_loop_system_select, 2))
		else $error("command unit does not follow system select");
	semi_system_a: assert property (!$past(closed_loop_system_select, 2) |-> !fully_closed_active)
		else $error("fully closed control in semi system");
	fixed_full_a: assert property ($past(closed_loop_system_select, 2) && !$past(loop_function_select, 2)
		|-> fully_closed_active) else $error("fixed mode not fully closed");
	cmd_full_a: assert property ($past(closed_loop_system_select, 2) && $past(loop_function_select, 2)
		&& $past(loop_select_command, 2) |-> fully_closed_active) else $error("command ignored");
	switch_pulse_a: assert property ($changed(fully_closed_active) |-> method_switched ##1 !method_switched)
		else $error("method change not flagged by one pulse");
	// alarms and absolute detection; alarm reports pass the latch first, one edge more
	par_raise_a: assert property ($past(loop_function_select, 3) && $past(absolute_detect_enable, 3)
		|-> parameter_error_alarm) else $error("parameter alarm missing");
	switched_abs_a: assert property ($past(closed_loop_system_select, 2) && $past(loop_function_select, 2)
		|-> !abs_detect_active) else $error("absolute detection in switched mode");
	semi_abs_a: assert property (!$past(closed_loop_system_select, 2) && $past(absolute_detect_enable, 2)
		|-> abs_detect_active) else $error("absolute detection missing in semi system");
	par_latch_a: assert property ($fell(parameter_error_alarm) |-> clr_seen != 3'h0)
		else $error("parameter alarm dropped without clear");
	enc_latch_a: assert property ($fell(encoder_config_alarm_a) |-> clr_seen != 3'h0)
		else $error("encoder alarm dropped without clear");
endmodule : clms_properties
`default_nettype wire

//--- bench/closed_loop_mode_select_tb.sv
// testbench: controller end and drive end joined by the link, driven from the register port
// assumes the package and link interface are compiled first
`default_nettype none
module closed_loop_mode_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import clms_pkg::*;
	logic         sys_clk = 1'h0;
	logic         rst_b = 1'h0;
	logic [7:0]   reg_addr = 8'h00;
	logic [31:0]  reg_wdata = 32'h0;
	logic         reg_wr = 1'h0;
	logic         reg_rd = 1'h0;
	logic [31:0]  reg_rdata;
	logic         irq;
	logic         lsel_in = 1'h0;
	logic         lsel_asg = 1'h0;
	logic         enc_pres = 1'h0;
	logic         enc_four = 1'h0;
	logic         enc_abz = 1'h0;
	logic         enc_rot = 1'h0;
	logic         enc_abs = 1'h0;
	logic         two_axis = 1'h0;
	clms_method_t control_method;
	logic         port_four_wire;
	logic         droop_clear_strobe;
	logic         alarm_any;
	int           n_mismatch = 0;
	int           checks = 0;
	int           cyc = 0;
	int           n_strobe = 0;
	clms_if link ();
	clms_controller clms_controller_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .abz_encoder_used(enc_abz), .two_axis_unit(two_axis), .irq(irq));
	clms_device clms_device_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
		.loop_select_input(lsel_in), .loop_select_assigned(lsel_asg), .encoder_present(enc_pres),
		.encoder_four_wire(enc_four), .encoder_abz(enc_abz), .encoder_abz_rotary(enc_rot),
		.encoder_absolute(enc_abs), .two_axis_unit(two_axis), .control_method(control_method),
		.port_four_wire(port_four_wire), .droop_clear_strobe(droop_clear_strobe),
		.alarm_any(alarm_any));
	clms_properties clms_properties_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.closed_loop_system_select(link.closed_loop_system_select),
		.loop_function_select(link.loop_function_select),
		.absolute_detect_enable(link.absolute_detect_enable),
		.loop_select_command(link.loop_select_command), .alarm_clear(link.alarm_clear),
		.fully_closed_active(link.fully_closed_active), .command_unit_load(link.command_unit_load),
		.abs_detect_active(link.abs_detect_active),
		.parameter_error_alarm(link.parameter_error_alarm),
		.encoder_config_alarm_a(link.encoder_config_alarm_a),
		.method_switched(link.method_switched));
	// clock, cycle count and strobe counting
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (droop_clear_strobe === 1'h1)
			n_strobe++;
	end
	task automatic give_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		checks++;
		if (got !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, got);
		end
	endtask : chk
	// register port cycles; outputs are looked at once the walk to the drive is over
	task automatic settle;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		settle();
	endtask : wr
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		chk(what, e & m, reg_rdata & m);
	endtask : rdc
	task automatic cfg(input logic s, f, a, d, w, c);
		wr(OFS_CTRL, {26'h0, c, w, d, a, f, s});
	endtask : cfg
	task automatic t_reset;
		rdc("ctrl", OFS_CTRL, 32'hFFFFFFFF, {26'h0, CTRL_RESET});
		rdc("mask", OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rdc("status", OFS_STATUS, 32'hFFFFFFFF, 32'h0);
		rdc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
		chk("droop", 32'h1, link.droop_clear_on_switch);
	endtask : t_reset
	task automatic t_modes;
		logic s, f, c, p, g, full;
		for (int i = 0; i < 32; i++)
		begin
			{g, p, c, f, s} = i[4:0];
			full = s & (!f | c | (p & g));
			@(posedge sys_clk);
			lsel_in <= p;
			lsel_asg <= g;
			cfg(s, f, 1'h0, 1'h1, 1'h0, c);
			rdc("full unit", OFS_STATUS, 32'h3, {30'h0, s, full});
			chk("method", full ? METH_FULL : METH_SEMI, control_method);
		end
	endtask : t_modes
	task automatic t_abs;
		logic s, ea, f;
		for (int i = 0; i < 8; i++)
		begin
			{f, ea, s} = i[2:0];
			@(posedge sys_clk);
			enc_abs <= ea;
			cfg(s, f, 1'h1, 1'h1, 1'h0, 1'h0);
			rdc("par abs", OFS_STATUS, 32'hC, {28'h0, f, !s | (!f & ea), 2'h0});
		end
		chk("irq masked", 32'h0, irq);
		rdc("irq stat", OFS_IRQ_STAT, 32'h1, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		chk("irq on", 32'h1, irq);
		wr(OFS_IRQ_STAT, 32'h1);
		chk("irq off", 32'h0, irq);
		wr(OFS_CMD, 32'h1);
		rdc("par cause", OFS_STATUS, 32'h8, 32'h8);
		cfg(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
		rdc("par held", OFS_STATUS, 32'h8, 32'h8);
		wr(OFS_CMD, 32'h1);
		rdc("par clear", OFS_STATUS, 32'h8, 32'h0);
	endtask : t_abs
	task automatic t_wire;
		logic w, e4;
		for (int i = 0; i < 4; i++)
		begin
			{e4, w} = i[1:0];
			@(posedge sys_clk);
			enc_pres <= 1'h1;
			enc_four <= e4;
			cfg(1'h0, 1'h0, 1'h0, 1'h1, w, 1'h0);
			// drop alarms latched while encoder and setting were out of step
			wr(OFS_CMD, 32'h1);
			chk("four wire", w, port_four_wire);
			rdc("enc alarms", OFS_STATUS, 32'h30, {26'h0, w ^ e4, w ^ e4, 4'h0});
			@(posedge sys_clk);
			enc_four <= w;
			wr(OFS_CMD, 32'h1);
			chk("alarm any", 32'h0, alarm_any);
		end
		@(posedge sys_clk);
		enc_abz <= 1'h1;
		enc_four <= 1'h0;
		cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
		chk("abz wire", 32'h0, port_four_wire);
		@(posedge sys_clk);
		two_axis <= 1'h1;
		enc_rot <= 1'h1;
		enc_abz <= 1'h0;
		wr(OFS_CTRL, 32'h18);
		chk("axis wire", 32'h0, port_four_wire);
		// the wire mismatch seen on the way here is gone; only the axis cause stays
		wr(OFS_CMD, 32'h1);
		rdc("axis alarm", OFS_STATUS, 32'h30, 32'h10);
	endtask : t_wire
	task automatic t_droop;
		int base;
		@(posedge sys_clk);
		lsel_asg <= 1'h0;
		cfg(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
		base = n_strobe;
		cfg(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
		chk("strobes", 32'h1, n_strobe - base);
		rdc("homing", OFS_STATUS, 32'h40, 32'h40);
		wr(OFS_CMD, 32'h2);
		rdc("homed", OFS_STATUS, 32'h40, 32'h0);
		cfg(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
		chk("no strobe", 32'h1, n_strobe - base);
	endtask : t_droop
	// main sequence
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'h1;
		fork
			begin
				t_reset();
				t_modes();
				t_abs();
				t_wire();
				t_droop();
			end
			// hang limit: the whole sequence needs well under a thousand cycles
			begin
				wait (cyc >= 5000);
				n_mismatch++;
			end
		join_any
		give_verdict();
	end
endmodule : closed_loop_mode_select_tb
`default_nettype wire
